/* File: logic/ebw_pkg.sv */
// Purpose: constants for the byte write control block
// Assumes: 8-bit control register at a chosen word index
// Notes: bit positions of the two flags are a local choice
package ebw_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h1;
    localparam int CAPTURE_BIT = 2;
    localparam int VOLTAGE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int ARR_AW = 14;
    localparam int ARR_DW = 8;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
endpackage : ebw_pkg

/* File: logic/ebw_write_control.sv */
// Purpose: byte write control for a one-time-programmable array
// Assumes: register port and array bus share one clock
// Notes: array access port mirrors the processor's array cycles
`timescale 1ns/1ns

// What this block does
// - with capture set, the next array write is latched for programming.
// - while capture is set, ordinary array reads are blocked.
// - with capture clear, the array paths serve ordinary reads.
// - the voltage flag drives the programming voltage on when 1, off when 0.
// - voltage may be set only if capture was set by an earlier write.
// - one write asking for both flags while capture is clear leaves only capture set; with capture already set it sets both.
// - both flags read back their current values.
module ebw_write_control
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [ebw_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [ebw_pkg::ARR_AW-1:0] arr_addr_in,
    input wire logic [ebw_pkg::ARR_DW-1:0] arr_wdata_in,
    input wire logic arr_wr_in,
    input wire logic arr_rd_in,
    output logic arr_rd_en_out,
    output logic [ebw_pkg::ARR_AW-1:0] nvm_write_control_addr_out,
    output logic [ebw_pkg::ARR_DW-1:0] nvm_write_control_data_out,
    output logic nvm_write_control_latched_out,
    output logic nvm_write_control_voltage_out
);
    import ebw_pkg::*;

    logic capture_q;
    logic voltage_q;
    logic latched_q;
    logic [ARR_AW-1:0] addr_q;
    logic [ARR_DW-1:0] data_q;
    logic [7:0] rdata_q;
    logic rd_en_q;
    logic ctrl_wr;
    logic [7:0] ctrl_val;

    assign ctrl_wr = reg_wr_in && (reg_addr_in == CTRL_OFFSET);
    assign ctrl_val = {5'h0_0, capture_q, 1'b0, voltage_q};

    // capture flag is freely writable
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            capture_q <= CTRL_RESET[CAPTURE_BIT];
        else if (ctrl_wr)
            capture_q <= reg_wdata_in[CAPTURE_BIT];
    end

    // voltage only when capture already stood before this write
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            voltage_q <= CTRL_RESET[VOLTAGE_BIT];
        else if (ctrl_wr)
            voltage_q <= reg_wdata_in[VOLTAGE_BIT] && capture_q;
    end

    // first array write after capture is held for programming
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            latched_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
        end
        else if (!capture_q)
            latched_q <= 1'b0;
        else if (arr_wr_in && !latched_q)
        begin
            latched_q <= 1'b1;
            addr_q <= arr_addr_in;
            data_q <= arr_wdata_in;
        end
    end

    // read enable toward the array follows the array read, one cycle later, and is held off while capture is set
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            rd_en_q <= 1'b0;
        else
            rd_en_q <= arr_rd_in && !capture_q;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            rdata_q <= 8'h00;
        else if (reg_rd_in && reg_addr_in == CTRL_OFFSET)
            rdata_q <= ctrl_val;
        else if (reg_rd_in && reg_addr_in == STAT_OFFSET)
            rdata_q <= {7'h00, latched_q};
        else
            rdata_q <= UNMAPPED_VALUE;
    end

    assign reg_rdata_out = rdata_q;
    assign arr_rd_en_out = rd_en_q;
    assign nvm_write_control_addr_out = addr_q;
    assign nvm_write_control_data_out = data_q;
    assign nvm_write_control_latched_out = latched_q;
    assign nvm_write_control_voltage_out = voltage_q;

    a_voltage_needs_capture: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (ctrl_wr && !capture_q) |=> !voltage_q)
        else $error("voltage set without earlier capture");

    a_never_both_set: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (ctrl_wr && !capture_q && reg_wdata_in[CAPTURE_BIT]
         && reg_wdata_in[VOLTAGE_BIT]) |=> (capture_q && !voltage_q))
        else $error("both flags set by one write");

    a_read_blocked: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (arr_rd_in && capture_q) |=> !arr_rd_en_out)
        else $error("array read while capture set");

    a_read_normal: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (arr_rd_in && !capture_q) |=> arr_rd_en_out)
        else $error("array read lost with capture clear");

    a_latch_write: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (capture_q && !latched_q && arr_wr_in && !ctrl_wr)
        |=> (latched_q && nvm_write_control_addr_out == $past(arr_addr_in)
             && nvm_write_control_data_out == $past(arr_wdata_in)))
        else $error("array write not latched");

    a_latch_holds: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (latched_q && capture_q) |=> $stable(nvm_write_control_addr_out))
        else $error("latched address changed");

    a_voltage_pin: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (ctrl_wr && capture_q && reg_wdata_in[VOLTAGE_BIT])
        |=> nvm_write_control_voltage_out)
        else $error("voltage not applied");

    a_ctrl_readback: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (reg_rd_in && reg_addr_in == CTRL_OFFSET)
        |=> reg_rdata_out == $past(ctrl_val))
        else $error("control readback wrong");

    a_status_readback: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (reg_rd_in && reg_addr_in == STAT_OFFSET)
        |=> reg_rdata_out == {7'h00, $past(latched_q)})
        else $error("status readback wrong");

    a_unmapped_zero: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (reg_rd_in && reg_addr_in != CTRL_OFFSET && reg_addr_in != STAT_OFFSET)
        |=> reg_rdata_out == UNMAPPED_VALUE)
        else $error("unmapped read not zero");

    a_rdata_idle: assert property (@(posedge clk_in)
        disable iff (reset_in)
        !reg_rd_in |=> reg_rdata_out == UNMAPPED_VALUE)
        else $error("read data outside its cycle");

    a_capture_write: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ctrl_wr |=> capture_q == $past(reg_wdata_in[CAPTURE_BIT]))
        else $error("capture flag not written");

    a_flags_hold: assert property (@(posedge clk_in)
        disable iff (reset_in)
        !ctrl_wr |=> ($stable(capture_q) && $stable(voltage_q)))
        else $error("flags changed without a write");

    a_voltage_clear: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (ctrl_wr && !reg_wdata_in[VOLTAGE_BIT]) |=> !nvm_write_control_voltage_out)
        else $error("voltage not removed");

    a_latch_drops: assert property (@(posedge clk_in)
        disable iff (reset_in)
        !capture_q |=> !nvm_write_control_latched_out)
        else $error("latch kept with capture clear");

    a_latch_data_holds: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (latched_q && capture_q) |=> $stable(nvm_write_control_data_out))
        else $error("latched data changed");

    a_capture_gates_read: assert property (@(posedge clk_in)
        disable iff (reset_in)
        capture_q |=> !arr_rd_en_out)
        else $error("read enabled while capture set");

    a_latch_needs_write: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (!latched_q && !(capture_q && arr_wr_in)) |=> !nvm_write_control_latched_out)
        else $error("latch set without array write");

    // reset is checked without the disable so its effect is seen
    a_reset_idle: assert property (@(posedge clk_in)
        reset_in
        |=> (!nvm_write_control_voltage_out && !nvm_write_control_latched_out && !arr_rd_en_out))
        else $error("outputs not idle after reset");
endmodule : ebw_write_control

/* File: sim/ebw_array_model.sv */
// Purpose: behavioural programmable array with its voltage switch
// Assumes: a byte burns while voltage is on and a write is latched
// Notes: only the most recently burnt byte is kept
`timescale 1ns/1ns
module ebw_array_model
(
    input wire logic clk_in,
    input wire logic voltage_in,
    input wire logic latched_in,
    input wire logic [7:0] data_in,
    output logic [7:0] burnt_out
);
    always_ff @(posedge clk_in)
    begin
        if (voltage_in && latched_in)
        begin
            burnt_out <= data_in;
        end
    end
endmodule : ebw_array_model

/* File: sim/tb_eprom_byte_write_control.sv */
// Purpose: self-checking bench for the byte write control
// Assumes: control at index 0, capture bit 2, voltage bit 0
// Notes: one task per scenario
`timescale 1ns/1ns
module tb_eprom_byte_write_control;
import ebw_pkg::*;
logic clk_in = 0, reset_in = 1, reg_wr_in = 0, reg_rd_in = 0;
logic arr_wr_in = 0, arr_rd_in = 0, arr_rd_en_out, latched, volt;
logic [ADDR_W-1:0] reg_addr_in = 4'h0;
logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, burnt;
logic [ARR_AW-1:0] arr_addr_in = 14'h0000, paddr;
logic [ARR_DW-1:0] arr_wdata_in = 8'h00, pdata;
int num_errors = 0, comparisons = 0;
ebw_write_control DUT (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .arr_addr_in(arr_addr_in),
    .arr_wdata_in(arr_wdata_in), .arr_wr_in(arr_wr_in),
    .arr_rd_in(arr_rd_in), .arr_rd_en_out(arr_rd_en_out),
    .nvm_write_control_addr_out(paddr), .nvm_write_control_data_out(pdata),
    .nvm_write_control_latched_out(latched), .nvm_write_control_voltage_out(volt));
ebw_array_model model (.clk_in(clk_in), .voltage_in(volt),
    .latched_in(latched), .data_in(pdata), .burnt_out(burnt));
initial
begin
    forever #50 clk_in = ~clk_in;
end
task automatic check(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e)
    begin
        num_errors++;
        $display("[ERR] %s exp %h seen %h", n, e, s);
    end
endtask : check
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #10;
endtask : wr
task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #10 check("rdata", reg_rdata_out, e);
endtask : rd
task automatic aw(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {arr_addr_in, arr_wdata_in, arr_wr_in} <= {a, d, 1'b1};
    @(posedge clk_in);
    arr_wr_in <= 1'b0;
    #10;
endtask : aw
task automatic t_refuse;
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h04);
endtask : t_refuse
task automatic t_program;
    @(posedge clk_in);
    arr_rd_in <= 1'b1;
    @(posedge clk_in);
    #10 check("rd_en", arr_rd_en_out, 0);
    aw(14'h0123, 8'ha5);
    aw(14'h0456, 8'h3c);
    check("addr", paddr, 16'h0123);
    check("data", pdata, 8'ha5);
    check("latched", latched, 1);
    rd(4'h1, 8'h01);
    wr(4'h0, 8'h05);
    check("volt", volt, 1);
    @(posedge clk_in);
    #10 check("burnt", burnt, 8'ha5);
    rd(4'h0, 8'h05);
    wr(4'h0, 8'h04);
    check("volt", volt, 0);
    wr(4'h0, 8'h00);
    @(posedge clk_in);
    #10 check("rd_en", arr_rd_en_out, 1);
    rd(4'h1, 8'h00);
    rd(4'h7, 8'h00);
endtask : t_program
task automatic conclude;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask : conclude
initial
begin
    #100_000 num_errors++;
    conclude;
end
initial
begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(4'h0, 8'h00);
    t_refuse;
    t_program;
    conclude;
end
endmodule : tb_eprom_byte_write_control
